// File: rtl/asp_check.sv
`include "asp_map.svh"
`default_nettype none
module asp_check (
  input  wire asp_pkg::asp_adv_type  i_adv,
  input  wire asp_pkg::asp_scan_type i_scan,
  output logic                       o_adv_ok,
  output logic                       o_scan_ok
);
  // ==========================================
  // argument range checks
  always_comb begin
    o_adv_ok = (i_adv.mode <= `ASP_ADV_MODE_MAX)
      && (i_adv.adv_kind <= `ASP_ADV_TYPE_MAX)
      && (i_adv.interval >= `ASP_ADV_INT_MIN)
      && (i_adv.interval <= `ASP_ADV_INT_MAX)
      && ((i_adv.channels & `ASP_ADV_CHAN_MASK) != 8'h00)
      && ((i_adv.channels & ~`ASP_ADV_CHAN_MASK) == 8'h00)
      && (i_adv.filter <= `ASP_FILT_MAX)
      && ((i_adv.flags & ~`ASP_ADV_FLAGS_MASK) == 8'h00);
    o_scan_ok = (i_scan.mode <= `ASP_SCAN_MODE_MAX)
      && (i_scan.interval >= `ASP_SCAN_INT_MIN)
      && (i_scan.interval <= `ASP_SCAN_INT_MAX)
      && (i_scan.window >= `ASP_SCAN_INT_MIN)
      && (i_scan.window <= i_scan.interval)
      && (i_scan.active <= `ASP_BOOL_MAX)
      && (i_scan.filter <= `ASP_FILT_MAX)
      && (i_scan.nodupe <= `ASP_BOOL_MAX);
  end
endmodule : asp_check
`default_nettype wire

// File: rtl/asp_device.sv
`include "asp_map.svh"
`default_nettype none
module asp_device (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  asp_if.device                       bus,
  output var asp_pkg::asp_adv_type    o_adv,
  output var asp_pkg::asp_scan_type   o_scan,
  output logic                        o_auto_adv,
  output logic                        o_custom_data,
  output logic                        o_active_scan,
  output logic                        o_dup_filter,
  output logic                        o_adv_timeout_en,
  output logic                        o_scan_timeout_en
);
  // ==========================================
  // factory defaults
  localparam asp_pkg::asp_adv_type ADV_DEF = '{
    mode: `ASP_ADV_MODE_DEF, adv_kind: `ASP_ADV_TYPE_DEF,
    interval: `ASP_ADV_INT_DEF, channels: `ASP_ADV_CHAN_DEF,
    filter: `ASP_ADV_FILT_DEF, timeout: `ASP_TIMEOUT_DEF,
    flags: `ASP_ADV_FLAGS_DEF};
  localparam asp_pkg::asp_scan_type SCAN_DEF = '{
    mode: `ASP_SCAN_MODE_DEF, interval: `ASP_SCAN_INT_DEF,
    window: `ASP_SCAN_WIN_DEF, active: `ASP_SCAN_ACT_DEF,
    filter: `ASP_SCAN_FILT_DEF, nodupe: `ASP_SCAN_DUP_DEF,
    timeout: `ASP_TIMEOUT_DEF};

  asp_pkg::asp_adv_type  adv;
  asp_pkg::asp_adv_type  next_adv;
  asp_pkg::asp_scan_type scan;
  asp_pkg::asp_scan_type next_scan;
  logic                  auto_adv;
  logic                  next_auto_adv;
  logic                  custom_data;
  logic                  next_custom_data;
  logic                  adv_timeout_en;
  logic                  next_adv_timeout_en;
  logic                  active_scan;
  logic                  next_active_scan;
  logic                  dup_filter;
  logic                  next_dup_filter;
  logic                  scan_timeout_en;
  logic                  next_scan_timeout_en;
  logic                  rsp_valid;
  logic                  next_rsp_valid;
  logic [7:0]            rsp_id;
  logic [7:0]            next_rsp_id;
  logic [15:0]           rsp_result;
  logic [15:0]           next_rsp_result;
  logic                  adv_ok;
  logic                  scan_ok;
  logic                  take_adv;
  logic                  take_scan;

  // ==========================================
  // argument checks
  // both sets are judged every cycle; only the decoded one is used
  asp_check u_check (
    .i_adv     (bus.cmd_adv),
    .i_scan    (bus.cmd_scan),
    .o_adv_ok  (adv_ok),
    .o_scan_ok (scan_ok)
  );

  // ==========================================
  // command decode
  // one command per cycle; answer follows one edge later
  // ready is tied high: every command is taken on the edge it is shown
  assign bus.cmd_ready = 1'b1;
  // a set lands only whole: one bad field leaves every field as it was
  assign take_adv  = bus.cmd_valid && (bus.cmd_id == `ASP_ID_SET_ADV) && adv_ok;
  assign take_scan = bus.cmd_valid && (bus.cmd_id == `ASP_ID_SET_SCAN) && scan_ok;

  // ==========================================
  // advertising set and its level outputs
  // levels follow next_adv so they move on the same edge as the set
  always_comb begin
    next_adv = adv;
    if (take_adv) begin
      next_adv = bus.cmd_adv;
    end
    next_auto_adv       = next_adv.flags[`ASP_FLAG_AUTO_BIT];
    next_custom_data    = next_adv.flags[`ASP_FLAG_CUST_BIT];
    next_adv_timeout_en = (next_adv.timeout != 16'h0000);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      adv            <= ADV_DEF;
      auto_adv       <= ADV_DEF.flags[`ASP_FLAG_AUTO_BIT];
      custom_data    <= ADV_DEF.flags[`ASP_FLAG_CUST_BIT];
      adv_timeout_en <= (ADV_DEF.timeout != 16'h0000);
    end else begin
      adv            <= next_adv;
      auto_adv       <= next_auto_adv;
      custom_data    <= next_custom_data;
      adv_timeout_en <= next_adv_timeout_en;
    end
  end

  // ==========================================
  // scan set and its level outputs
  always_comb begin
    next_scan = scan;
    if (take_scan) begin
      next_scan = bus.cmd_scan;
    end
    next_active_scan     = next_scan.active[0];
    next_dup_filter      = next_scan.nodupe[0];
    next_scan_timeout_en = (next_scan.timeout != 16'h0000);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      scan            <= SCAN_DEF;
      active_scan     <= SCAN_DEF.active[0];
      dup_filter      <= SCAN_DEF.nodupe[0];
      scan_timeout_en <= (SCAN_DEF.timeout != 16'h0000);
    end else begin
      scan            <= next_scan;
      active_scan     <= next_active_scan;
      dup_filter      <= next_dup_filter;
      scan_timeout_en <= next_scan_timeout_en;
    end
  end

  // ==========================================
  // response
  // unknown ids still answer, so the host never waits for nothing
  // id and result hold between answers; valid is a one-cycle pulse
  always_comb begin
    next_rsp_valid  = 1'b0;
    next_rsp_id     = rsp_id;
    next_rsp_result = rsp_result;
    if (bus.cmd_valid) begin
      next_rsp_valid = 1'b1;
      next_rsp_id    = bus.cmd_id;
      unique case (bus.cmd_id)
        `ASP_ID_SET_ADV: begin
          next_rsp_result = adv_ok ? `ASP_RES_OK : `ASP_RES_BAD_ARG;
        end
        `ASP_ID_SET_SCAN: begin
          next_rsp_result = scan_ok ? `ASP_RES_OK : `ASP_RES_BAD_ARG;
        end
        `ASP_ID_GET_ADV,
        `ASP_ID_GET_SCAN: begin
          next_rsp_result = `ASP_RES_OK;
        end
        default: begin
          next_rsp_result = `ASP_RES_BAD_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rsp_valid  <= 1'b0;
      rsp_id     <= 8'h00;
      rsp_result <= 16'h0000;
    end else begin
      rsp_valid  <= next_rsp_valid;
      rsp_id     <= next_rsp_id;
      rsp_result <= next_rsp_result;
    end
  end

  // ==========================================
  // responses and stored sets back to the host side
  // stored sets are always shown; host takes them on rsp_valid and ignores rsp_id
  assign bus.rsp_valid  = rsp_valid;
  assign bus.rsp_id     = rsp_id;
  assign bus.rsp_result = rsp_result;
  assign bus.rsp_adv    = adv;
  assign bus.rsp_scan   = scan;

  // settings leave as levels only; timeouts are not range checked
  assign o_adv             = adv;
  assign o_scan            = scan;
  assign o_auto_adv        = auto_adv;
  assign o_custom_data     = custom_data;
  assign o_active_scan     = active_scan;
  assign o_dup_filter      = dup_filter;
  assign o_adv_timeout_en  = adv_timeout_en;
  assign o_scan_timeout_en = scan_timeout_en;
endmodule : asp_device
`default_nettype wire

// File: rtl/asp_host.sv
`include "asp_map.svh"
`default_nettype none
module asp_host (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  asp_if.host                         bus,
  input  wire logic                   i_req,
  input  wire logic [7:0]             i_id,
  input  wire asp_pkg::asp_adv_type   i_adv,
  input  wire asp_pkg::asp_scan_type  i_scan,
  output logic                        o_busy,
  output logic                        o_done,
  output logic [15:0]                 o_result,
  output var asp_pkg::asp_adv_type    o_adv,
  output var asp_pkg::asp_scan_type   o_scan
);
  asp_pkg::asp_host_state_type state;
  asp_pkg::asp_host_state_type next_state;
  logic [7:0]            id;
  logic [7:0]            next_id;
  asp_pkg::asp_adv_type  adv;
  asp_pkg::asp_adv_type  next_adv;
  asp_pkg::asp_scan_type scan;
  asp_pkg::asp_scan_type next_scan;
  logic                  done;
  logic                  next_done;
  logic [15:0]           result;
  logic [15:0]           next_result;
  asp_pkg::asp_adv_type  r_adv;
  asp_pkg::asp_adv_type  next_r_adv;
  asp_pkg::asp_scan_type r_scan;
  asp_pkg::asp_scan_type next_r_scan;

  // ==========================================
  // one command outstanding at a time
  always_comb begin
    next_state  = state;
    next_id     = id;
    next_adv    = adv;
    next_scan   = scan;
    next_done   = 1'b0;
    next_result = result;
    next_r_adv  = r_adv;
    next_r_scan = r_scan;
    unique case (state)
      asp_pkg::ASP_IDLE: begin
        if (i_req) begin
          next_state = asp_pkg::ASP_REQ;
          next_id    = i_id;
          next_adv   = i_adv;
          next_scan  = i_scan;
        end
      end
      asp_pkg::ASP_REQ: begin
        if (bus.cmd_ready) begin
          next_state = asp_pkg::ASP_WAIT;
        end
      end
      asp_pkg::ASP_WAIT: begin
        if (bus.rsp_valid) begin
          next_state  = asp_pkg::ASP_IDLE;
          next_done   = 1'b1;
          next_result = bus.rsp_result;
          next_r_adv  = bus.rsp_adv;
          next_r_scan = bus.rsp_scan;
        end
      end
      default: begin
        next_state = asp_pkg::ASP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state  <= asp_pkg::ASP_IDLE;
      id     <= 8'h00;
      adv    <= '0;
      scan   <= '0;
      done   <= 1'b0;
      result <= 16'h0000;
      r_adv  <= '0;
      r_scan <= '0;
    end else begin
      state  <= next_state;
      id     <= next_id;
      adv    <= next_adv;
      scan   <= next_scan;
      done   <= next_done;
      result <= next_result;
      r_adv  <= next_r_adv;
      r_scan <= next_r_scan;
    end
  end

  assign bus.cmd_valid = (state == asp_pkg::ASP_REQ);
  assign bus.cmd_id    = id;
  assign bus.cmd_adv   = adv;
  assign bus.cmd_scan  = scan;
  assign o_busy        = (state != asp_pkg::ASP_IDLE);
  assign o_done        = done;
  assign o_result      = result;
  assign o_adv         = r_adv;
  assign o_scan        = r_scan;
endmodule : asp_host
`default_nettype wire

// File: rtl/asp_if.sv
`default_nettype none
interface asp_if;
  // command channel: host to device, with cmd_ready driven back from device to host
  logic                 cmd_valid;
  logic                 cmd_ready;
  logic [7:0]           cmd_id;
  asp_pkg::asp_adv_type  cmd_adv;
  asp_pkg::asp_scan_type cmd_scan;
  // response channel: device to host
  logic                 rsp_valid;
  logic [7:0]           rsp_id;
  logic [15:0]          rsp_result;
  asp_pkg::asp_adv_type  rsp_adv;
  asp_pkg::asp_scan_type rsp_scan;

  modport device (
    input  cmd_valid, cmd_id, cmd_adv, cmd_scan,
    output cmd_ready, rsp_valid, rsp_id, rsp_result, rsp_adv, rsp_scan
  );
  modport host (
    output cmd_valid, cmd_id, cmd_adv, cmd_scan,
    input  cmd_ready, rsp_valid, rsp_id, rsp_result, rsp_adv, rsp_scan
  );
endinterface : asp_if
`default_nettype wire

// File: rtl/asp_map.svh
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
// ==========================================
// command ids
`define ASP_ID_SET_ADV     8'h17
`define ASP_ID_GET_ADV     8'h18
`define ASP_ID_SET_SCAN    8'h19
`define ASP_ID_GET_SCAN    8'h1a
// ==========================================
// result codes
`define ASP_RES_OK         16'h0000
`define ASP_RES_BAD_ARG    16'h0001
`define ASP_RES_BAD_CMD    16'h0002
// ==========================================
// advertising defaults and limits
`define ASP_ADV_MODE_DEF   8'h02
`define ASP_ADV_TYPE_DEF   8'h00
`define ASP_ADV_INT_MIN    16'h0020
`define ASP_ADV_INT_MAX    16'h4000
`define ASP_ADV_INT_DEF    16'h0030
`define ASP_ADV_CHAN_DEF   8'h07
`define ASP_ADV_CHAN_MASK  8'h07
`define ASP_ADV_FILT_DEF   8'h00
`define ASP_TIMEOUT_DEF    16'h0000
`define ASP_ADV_FLAGS_DEF  8'h00
`define ASP_FLAG_AUTO_BIT  0
`define ASP_FLAG_CUST_BIT  1
`define ASP_ADV_FLAGS_MASK 8'h03
`define ASP_ADV_MODE_MAX   8'h02
`define ASP_ADV_TYPE_MAX   8'h03
`define ASP_FILT_MAX       8'h03
// ==========================================
// scan defaults and limits
`define ASP_SCAN_MODE_DEF  8'h02
`define ASP_SCAN_MODE_MAX  8'h02
`define ASP_SCAN_INT_MIN   16'h0004
`define ASP_SCAN_INT_MAX   16'h4000
`define ASP_SCAN_INT_DEF   16'h0100
`define ASP_SCAN_WIN_DEF   16'h0100
`define ASP_SCAN_ACT_DEF   8'h00
`define ASP_SCAN_FILT_DEF  8'h00
`define ASP_SCAN_DUP_DEF   8'h00
`define ASP_BOOL_MAX       8'h01
`endif

// File: rtl/asp_pkg.sv
`default_nettype none
package asp_pkg;
  // ==========================================
  // stored parameter sets
  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  adv_kind;
    logic [15:0] interval;
    logic [7:0]  channels;
    logic [7:0]  filter;
    logic [15:0] timeout;
    logic [7:0]  flags;
  } asp_adv_type;

  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] interval;
    logic [15:0] window;
    logic [7:0]  active;
    logic [7:0]  filter;
    logic [7:0]  nodupe;
    logic [15:0] timeout;
  } asp_scan_type;

  typedef enum logic [1:0] {
    ASP_IDLE = 2'b00,
    ASP_REQ  = 2'b01,
    ASP_WAIT = 2'b10
  } asp_host_state_type;
endpackage : asp_pkg
`default_nettype wire

// File: test/adv_scan_param_commands_tb.sv
`include "asp_map.svh"
`default_nettype none
module adv_scan_param_commands_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  i_mclk = 1'b0;
  logic                  i_reset = 1'b1;
  logic                  req = 1'b0;
  logic [7:0]            id = 8'h00;
  asp_pkg::asp_adv_type  adv = '0;
  asp_pkg::asp_scan_type scn = '0;
  logic                  busy, done, auto_adv, cust, act, dup, adv_to, scan_to;
  logic [15:0]           res;
  asp_pkg::asp_adv_type  got_adv, exp_adv, dev_adv;
  asp_pkg::asp_scan_type got_scan, exp_scan, dev_scan;
  int                    miscompares = 0;
  int                    n_tests = 0;
  asp_if bus ();
  always #50 i_mclk = ~i_mclk;
  asp_device u_asp_device (.i_mclk(i_mclk), .i_reset(i_reset), .bus(bus.device),
    .o_adv(dev_adv), .o_scan(dev_scan), .o_auto_adv(auto_adv), .o_custom_data(cust),
    .o_active_scan(act), .o_dup_filter(dup), .o_adv_timeout_en(adv_to),
    .o_scan_timeout_en(scan_to));
  asp_host u_asp_host (.i_mclk(i_mclk), .i_reset(i_reset), .bus(bus.host), .i_req(req),
    .i_id(id), .i_adv(adv), .i_scan(scn), .o_busy(busy), .o_done(done), .o_result(res),
    .o_adv(got_adv), .o_scan(got_scan));
  asp_properties u_asp_properties (.i_mclk(i_mclk), .i_reset(i_reset),
    .cmd_valid(bus.cmd_valid), .cmd_ready(bus.cmd_ready), .cmd_id(bus.cmd_id),
    .cmd_adv(bus.cmd_adv), .cmd_scan(bus.cmd_scan), .rsp_valid(bus.rsp_valid),
    .rsp_id(bus.rsp_id), .rsp_result(bus.rsp_result), .rsp_adv(bus.rsp_adv),
    .rsp_scan(bus.rsp_scan));
  // ==========================================
  // shared tasks
  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one command through the host port, bounded wait for done
  task automatic send(input logic [7:0] cid, input logic [15:0] exp_res);
    id = cid;
    req = 1'b1;
    @(posedge i_mclk);
    #10 req = 1'b0;
    check(busy, 1'b1);
    for (int k = 0; k < 8 && done !== 1'b1; k++) begin
      @(posedge i_mclk);
      #10;
    end
    check(done, 1'b1);
    check(busy, 1'b0);
    check(res, exp_res);
  endtask : send
  task automatic defaults();
    send(`ASP_ID_GET_ADV, `ASP_RES_OK);
    check(got_adv, {8'h02, 8'h00, 16'h0030, 8'h07, 8'h00, 16'h0000, 8'h00});
    send(`ASP_ID_GET_SCAN, `ASP_RES_OK);
    check(got_scan, {8'h02, 16'h0100, 16'h0100, 8'h00, 8'h00, 8'h00, 16'h0000});
    check(dev_scan, {8'h02, 16'h0100, 16'h0100, 8'h00, 8'h00, 8'h00, 16'h0000});
    check({auto_adv, cust, act, dup, adv_to, scan_to}, 6'h00);
  endtask : defaults
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // ==========================================
  // tests
  initial begin
    repeat (3) @(posedge i_mclk);
    #10 i_reset = 1'b0;
    defaults();
    for (int i = 0; i < 4; i++) begin
      adv = '{8'(i % 3), 8'(i), i[1] ? 16'h4000 : 16'h0020, 8'(1 << (i % 3)) | 8'(i), 8'(i),
        16'(i), 8'(i)};
      send(`ASP_ID_SET_ADV, `ASP_RES_OK);
      send(`ASP_ID_GET_ADV, `ASP_RES_OK);
      check(got_adv, adv);
      check(dev_adv, adv);
      check({auto_adv, cust, adv_to}, {adv.flags[0], adv.flags[1], adv.timeout != 0});
    end
    exp_adv = adv;
    for (int j = 0; j < 7; j++) begin
      adv = exp_adv;
      case (j)
        0: adv.mode = 8'h03;
        1: adv.interval = 16'h001f;
        2: adv.interval = 16'h4001;
        3: adv.channels = 8'h00;
        4: adv.adv_kind = 8'h04;
        5: adv.filter = 8'h04;
        default: adv.channels = 8'h08;
      endcase
      send(`ASP_ID_SET_ADV, `ASP_RES_BAD_ARG);
      send(`ASP_ID_GET_ADV, `ASP_RES_OK);
      check(got_adv, exp_adv);
      check(dev_adv, exp_adv);
    end
    for (int i = 0; i < 3; i++) begin
      scn = '{8'(i), i[0] ? 16'h4000 : 16'h0004, i[0] ? 16'h4000 : 16'h0004, 8'(i & 1),
        8'(i + 1), 8'(i & 1), 16'(i)};
      send(`ASP_ID_SET_SCAN, `ASP_RES_OK);
      send(`ASP_ID_GET_SCAN, `ASP_RES_OK);
      check(got_scan, scn);
      check(dev_scan, scn);
      check({act, dup, scan_to}, {scn.active[0], scn.nodupe[0], scn.timeout != 0});
    end
    exp_scan = scn;
    for (int j = 0; j < 8; j++) begin
      scn = exp_scan;
      case (j)
        0: scn.window = 16'h0005;
        1: scn.window = 16'h0003;
        2: scn.interval = 16'h0003;
        3: scn.interval = 16'h4001;
        4: scn.mode = 8'h03;
        5: scn.active = 8'h02;
        6: scn.filter = 8'h04;
        default: scn.nodupe = 8'h02;
      endcase
      send(`ASP_ID_SET_SCAN, `ASP_RES_BAD_ARG);
      send(`ASP_ID_GET_SCAN, `ASP_RES_OK);
      check(got_scan, exp_scan);
      check(dev_scan, exp_scan);
    end
    send(8'h55, `ASP_RES_BAD_CMD);
    // second reset mid-run must restore factory values
    i_reset = 1'b1;
    repeat (2) @(posedge i_mclk);
    #10 i_reset = 1'b0;
    defaults();
    conclude();
  end
  // ==========================================
  // watchdog, about ten times the expected run
  initial begin
    #160000;
    miscompares++;
    conclude();
  end
endmodule : adv_scan_param_commands_tb
`default_nettype wire

// File: test/asp_properties.sv
`include "asp_map.svh"
`default_nettype none
module asp_properties (
  input wire logic                  i_mclk,
  input wire logic                  i_reset,
  input wire logic                  cmd_valid,
  input wire logic                  cmd_ready,
  input wire logic [7:0]            cmd_id,
  input wire asp_pkg::asp_adv_type  cmd_adv,
  input wire asp_pkg::asp_scan_type cmd_scan,
  input wire logic                  rsp_valid,
  input wire logic [7:0]            rsp_id,
  input wire logic [15:0]           rsp_result,
  input wire asp_pkg::asp_adv_type  rsp_adv,
  input wire asp_pkg::asp_scan_type rsp_scan
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  // ==========================================
  // stored sets stay legal at all times
  chk_adv_mode: assert property (rsp_adv.mode <= 8'h02)
    else $error("adv mode out of range");
  chk_adv_kind: assert property (rsp_adv.adv_kind <= 8'h03)
    else $error("adv type out of range");
  chk_adv_ival: assert property (rsp_adv.interval inside {[16'h0020:16'h4000]})
    else $error("adv interval out of range");
  chk_adv_chan: assert property (rsp_adv.channels != 8'h00 && rsp_adv.channels <= 8'h07)
    else $error("adv channel mask illegal");
  chk_adv_filt: assert property (rsp_adv.filter <= 8'h03)
    else $error("adv filter out of range");
  chk_scan_mode: assert property (rsp_scan.mode <= 8'h02)
    else $error("scan mode out of range");
  chk_scan_ival: assert property (rsp_scan.interval inside {[16'h0004:16'h4000]})
    else $error("scan interval out of range");
  chk_scan_win: assert property (rsp_scan.window >= 16'h0004 && rsp_scan.window <= rsp_scan.interval)
    else $error("scan window illegal");
  chk_scan_flags: assert property (rsp_scan.active <= 8'h01 && rsp_scan.nodupe <= 8'h01)
    else $error("scan boolean field illegal");
  chk_scan_filt: assert property (rsp_scan.filter <= 8'h03)
    else $error("scan filter out of range");
  // ==========================================
  // answers tied to the command that caused them
  chk_rsp_follows: assert property (cmd_valid |=> rsp_valid && rsp_id == $past(cmd_id))
    else $error("response missing or wrong id");
  chk_scan_store: assert property ((cmd_valid && cmd_id == `ASP_ID_SET_SCAN) ##1
    (rsp_result == `ASP_RES_OK) |-> rsp_scan == $past(cmd_scan))
    else $error("accepted scan set not stored");
  chk_keep_on_error: assert property ((cmd_valid && cmd_id inside {`ASP_ID_SET_ADV, `ASP_ID_SET_SCAN})
    ##1 (rsp_result == `ASP_RES_BAD_ARG) |-> $stable(rsp_adv) && $stable(rsp_scan))
    else $error("rejected set changed state");
endmodule : asp_properties
`default_nettype wire
